// ---- core/dsw_bank.sv ----
// Drive status word bank: warning latch, action word and stop-fault code.
// Assumes monitor inputs are from the controller clock; safety inputs are pins.
`include "dsw_defines.svh"
`default_nettype none

// What this block does
// - Provides a 16-bit read-only latched warning word, one bit per condition.
// - A fault-clear command clears every latched warning bit whose condition is no longer present.
// - Latched bits 10, 11 and 13 clear themselves once the condition ends.
// - Bit 0 flags any warning; the latest code is reported separately.
// - Bit 1 power stage hot, bit 2 motor hot, bit 3 reserved.
// - Bits 4, 5, 6 flag overload of power stage, motor, braking resistor.
// - Bit 7 CAN warning, bit 9 RS485 warning, bit 12 third fieldbus warning.
// - Bit 8 flags a motor encoder warning.
// - Bit 10 set when either power-removal input is inactive.
// - Bit 11 undervoltage or mains phase, bit 13 position not valid; 14-15 reserved.
// - Bit meanings may depend on control mode; reader interprets accordingly.
// - Action bits 0-4 flag error class 0-4; bit 5 reserved.
// - Action bit 6 set while speed magnitude is below 9 rpm.
// - Action bit 7 positive rotation, bit 8 negative rotation.
// - Action bit 9 set inside position window; bit 10 reserved.
// - Action bit 11 set when profile generator speed setpoint is zero.
// - Action bits 12, 13, 14: decelerate, accelerate, constant; bit 15 reserved.
// - A 16-bit read-only word holds the fault code of the last stop.
// - A read-only active warning word uses the latched word's meanings.
module dsw_bank
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic power_removal_input_a,
   input wire logic power_removal_input_b,
   input wire logic warn_power_stage_hot,
   input wire logic warn_motor_hot,
   input wire logic warn_i2t_power_stage,
   input wire logic warn_i2t_motor,
   input wire logic warn_i2t_brake_res,
   input wire logic warn_can,
   input wire logic warn_encoder,
   input wire logic warn_rs485,
   input wire logic warn_dc_undervolt,
   input wire logic warn_fieldbus3,
   input wire logic warn_pos_invalid,
   input wire logic fault_clear_command,
   input wire logic [15:0] speed_abs_rpm,
   input wire dsw_pkg::dsw_motion_type motion,
   input wire logic stop_fault_strobe,
   input wire logic [15:0] stop_fault_code,
   input wire logic rd_en,
   input wire logic [15:0] rd_addr,
   output logic [15:0] rd_data,
   output logic rd_valid,
   output logic [15:0] active_warning_word,
   output logic [15:0] latched_warning_word
);
   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   dsw_pkg::dsw_state_type st_ff;
   dsw_pkg::dsw_state_type nxt_st;
   logic [15:0] cond;
   logic [15:0] keep;

   always_comb
   begin
      nxt_st = st_ff;
      // Two flops stand between the safety pins and any logic
      nxt_st.pwr_meta_ff = {power_removal_input_b, power_removal_input_a};
      nxt_st.pwr_sync_ff = st_ff.pwr_meta_ff;
      cond = 16'h0000;
      // One fixed bit map; the reader applies the mode in force
      cond[1] = warn_power_stage_hot;
      cond[2] = warn_motor_hot;
      cond[4] = warn_i2t_power_stage;
      cond[5] = warn_i2t_motor;
      cond[6] = warn_i2t_brake_res;
      cond[7] = warn_can;
      cond[8] = warn_encoder;
      cond[9] = warn_rs485;
      cond[10] = ~(&st_ff.pwr_sync_ff);
      cond[11] = warn_dc_undervolt;
      cond[12] = warn_fieldbus3;
      cond[13] = warn_pos_invalid;
      cond[`DSW_WARN_GENERAL] = |cond;
      cond = cond & `DSW_WARN_VALID_MASK;
      nxt_st.active_ff = cond;
      // Self-clearing bits track the live condition; set still wins
      keep = fault_clear_command ? 16'h0000 : st_ff.latched_ff;
      keep = keep & ~(`DSW_WARN_AUTO_MASK & ~cond);
      nxt_st.latched_ff = keep | cond;
      nxt_st.action_ff = 16'h0000;
      nxt_st.action_ff[4:0] = motion.err_class;
      nxt_st.action_ff[6] = speed_abs_rpm < `DSW_STANDSTILL_RPM;
      nxt_st.action_ff[7] = motion.pos_dir;
      nxt_st.action_ff[8] = motion.neg_dir;
      nxt_st.action_ff[9] = motion.in_window;
      nxt_st.action_ff[11] = motion.pg_stopped;
      nxt_st.action_ff[12] = motion.pg_decel;
      nxt_st.action_ff[13] = motion.pg_accel;
      nxt_st.action_ff[14] = motion.pg_const;
      if (stop_fault_strobe)
      begin
         nxt_st.stopf_ff = stop_fault_code;
      end
      // Read-only map; there is no write path at all
      nxt_st.rvalid_ff = rd_en;
      nxt_st.rdata_ff = 16'h0000;
      if (rd_en)
      begin
         unique case (rd_addr)
            `DSW_ADDR_ACTION: nxt_st.rdata_ff = st_ff.action_ff;
            `DSW_ADDR_STOPF: nxt_st.rdata_ff = st_ff.stopf_ff;
            `DSW_ADDR_LATCHED: nxt_st.rdata_ff = st_ff.latched_ff;
            `DSW_ADDR_ACTIVE: nxt_st.rdata_ff = st_ff.active_ff;
            default: nxt_st.rdata_ff = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff <= '0;
         st_ff.pwr_meta_ff <= `DSW_PWR_SYNC_RESET;
         st_ff.pwr_sync_ff <= `DSW_PWR_SYNC_RESET;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign rd_data = st_ff.rdata_ff;
   assign rd_valid = st_ff.rvalid_ff;
   assign active_warning_word = st_ff.active_ff;
   assign latched_warning_word = st_ff.latched_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_clear_wipes: assert property (@(posedge clk) disable iff (!rst_n)
      fault_clear_command && !(|cond) |=> st_ff.latched_ff == 16'h0000)
      else $error("latched word not cleared");
   a_latch_holds: assert property (@(posedge clk) disable iff (!rst_n)
      !fault_clear_command && st_ff.latched_ff[1] |=> st_ff.latched_ff[1])
      else $error("latched bit dropped");
   a_auto_clear: assert property (@(posedge clk) disable iff (!rst_n)
      !cond[11] |=> !st_ff.latched_ff[11])
      else $error("bit 11 not self cleared");
   a_general_bit: assert property (@(posedge clk) disable iff (!rst_n)
      (|st_ff.active_ff) == st_ff.active_ff[0])
      else $error("general bit mismatch");
   a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
      (st_ff.latched_ff & ~`DSW_WARN_VALID_MASK) == 16'h0000
      && (st_ff.action_ff & ~`DSW_ACT_VALID_MASK) == 16'h0000)
      else $error("reserved bit set");
   a_standstill: assert property (@(posedge clk) disable iff (!rst_n)
      speed_abs_rpm < 16'h0009 |=> st_ff.action_ff[6])
      else $error("standstill missing");
   a_pwr_warn: assert property (@(posedge clk) disable iff (!rst_n)
      !power_removal_input_a |-> ##3 st_ff.active_ff[10])
      else $error("power removal warning missing");
   a_stop_code: assert property (@(posedge clk) disable iff (!rst_n)
      stop_fault_strobe |=> st_ff.stopf_ff == $past(stop_fault_code))
      else $error("stop code not held");
   a_read_latch: assert property (@(posedge clk) disable iff (!rst_n)
      rd_en && rd_addr == `DSW_ADDR_LATCHED |=> rd_valid
      && rd_data == $past(st_ff.latched_ff))
      else $error("latched read wrong");

   // ----------------------------------------------------------------
   // Warning bit map
   // ----------------------------------------------------------------
   a_temp_stage: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> st_ff.active_ff[1] == $past(warn_power_stage_hot))
      else $error("power stage heat bit wrong");
   a_temp_motor: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> st_ff.active_ff[2] == $past(warn_motor_hot))
      else $error("motor heat bit wrong");
   a_bit3_zero: assert property (@(posedge clk) disable iff (!rst_n)
      !st_ff.active_ff[3] && !st_ff.latched_ff[3])
      else $error("reserved bit 3 set");
   a_i2t_stage: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> st_ff.active_ff[4] == $past(warn_i2t_power_stage))
      else $error("stage overload bit wrong");
   a_i2t_motor: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> st_ff.active_ff[5] == $past(warn_i2t_motor))
      else $error("motor overload bit wrong");
   a_i2t_brake: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> st_ff.active_ff[6] == $past(warn_i2t_brake_res))
      else $error("brake overload bit wrong");
   a_can_warn: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> st_ff.active_ff[7] == $past(warn_can))
      else $error("can bit wrong");
   a_encoder_warn: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> st_ff.active_ff[8] == $past(warn_encoder))
      else $error("encoder bit wrong");
   a_rs485_warn: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> st_ff.active_ff[9] == $past(warn_rs485))
      else $error("rs485 bit wrong");
   a_bus3_warn: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> st_ff.active_ff[12] == $past(warn_fieldbus3))
      else $error("third bus bit wrong");
   a_undervolt_warn: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> st_ff.active_ff[11] == $past(warn_dc_undervolt))
      else $error("undervoltage bit wrong");
   a_pos_invalid: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> st_ff.active_ff[13] == $past(warn_pos_invalid))
      else $error("position bit wrong");
   a_top_reserved: assert property (@(posedge clk) disable iff (!rst_n)
      st_ff.active_ff[15:14] == 2'h0)
      else $error("reserved top bits set");
   a_pwr_b_warn: assert property (@(posedge clk) disable iff (!rst_n)
      !power_removal_input_b |-> ##3 st_ff.active_ff[10])
      else $error("second power removal warning missing");
   a_pwr_ok: assert property (@(posedge clk) disable iff (!rst_n)
      st_ff.pwr_sync_ff == 2'h3 |=> !st_ff.active_ff[10])
      else $error("power removal warning without cause");

   // ----------------------------------------------------------------
   // Latch behaviour
   // ----------------------------------------------------------------
   a_latch_sets: assert property (@(posedge clk) disable iff (!rst_n)
      (st_ff.active_ff & ~st_ff.latched_ff) == 16'h0000)
      else $error("active bit not latched");
   a_latch_general: assert property (@(posedge clk) disable iff (!rst_n)
      (|st_ff.latched_ff) |-> st_ff.latched_ff[`DSW_WARN_GENERAL])
      else $error("latched general bit missing");
   a_auto_ten: assert property (@(posedge clk) disable iff (!rst_n)
      !cond[10] |=> !st_ff.latched_ff[10])
      else $error("bit 10 not self cleared");
   a_auto_thirteen: assert property (@(posedge clk) disable iff (!rst_n)
      !cond[13] |=> !st_ff.latched_ff[13])
      else $error("bit 13 not self cleared");
   // Set beats clear: a warning present at the clear stays latched
   a_clear_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
      fault_clear_command |=> st_ff.latched_ff == $past(cond))
      else $error("clear result wrong");
   a_latch_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      !fault_clear_command |=> ($past(st_ff.latched_ff) & ~`DSW_WARN_AUTO_MASK
      & ~st_ff.latched_ff) == 16'h0000)
      else $error("sticky bit dropped");

   // ----------------------------------------------------------------
   // Action word and stop code
   // ----------------------------------------------------------------
   a_err_class: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> st_ff.action_ff[4:0] == $past(motion.err_class))
      else $error("error class bits wrong");
   a_moving: assert property (@(posedge clk) disable iff (!rst_n)
      speed_abs_rpm >= `DSW_STANDSTILL_RPM |=> !st_ff.action_ff[6])
      else $error("standstill while moving");
   a_dir_pos: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> st_ff.action_ff[7] == $past(motion.pos_dir))
      else $error("positive direction bit wrong");
   a_dir_neg: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> st_ff.action_ff[8] == $past(motion.neg_dir))
      else $error("negative direction bit wrong");
   a_window: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> st_ff.action_ff[9] == $past(motion.in_window))
      else $error("window bit wrong");
   a_pg_stop: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> st_ff.action_ff[11] == $past(motion.pg_stopped))
      else $error("generator stop bit wrong");
   a_pg_decel: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> st_ff.action_ff[12] == $past(motion.pg_decel))
      else $error("deceleration bit wrong");
   a_pg_accel: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> st_ff.action_ff[13] == $past(motion.pg_accel))
      else $error("acceleration bit wrong");
   a_pg_const: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> st_ff.action_ff[14] == $past(motion.pg_const))
      else $error("constant speed bit wrong");
   a_stop_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !stop_fault_strobe |=> $stable(st_ff.stopf_ff))
      else $error("stop code changed without strobe");

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   // Answer lands one edge after the request
   a_active_read: assert property (@(posedge clk) disable iff (!rst_n)
      rd_en && rd_addr == `DSW_ADDR_ACTIVE |=> rd_data == $past(st_ff.active_ff))
      else $error("active read wrong");
   a_action_read: assert property (@(posedge clk) disable iff (!rst_n)
      rd_en && rd_addr == `DSW_ADDR_ACTION |=> rd_data == $past(st_ff.action_ff))
      else $error("action read wrong");
   a_stopf_read: assert property (@(posedge clk) disable iff (!rst_n)
      rd_en && rd_addr == `DSW_ADDR_STOPF |=> rd_data == $past(st_ff.stopf_ff))
      else $error("stop code read wrong");
   a_unmapped_read: assert property (@(posedge clk) disable iff (!rst_n)
      rd_en && rd_addr != `DSW_ADDR_ACTION && rd_addr != `DSW_ADDR_STOPF
      && rd_addr != `DSW_ADDR_LATCHED && rd_addr != `DSW_ADDR_ACTIVE
      |=> rd_valid && rd_data == 16'h0000)
      else $error("unmapped read not zero");
   a_valid_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> rd_valid == $past(rd_en))
      else $error("read valid wrong");
   a_idle_data: assert property (@(posedge clk) disable iff (!rst_n)
      !rd_en |=> rd_data == 16'h0000)
      else $error("read data without request");
endmodule : dsw_bank
`default_nettype wire

// ---- pkg/dsw_defines.svh ----
// Offsets, field positions and reset values of the drive status word bank.
// Assumes inclusion by bare name from the core file.
`ifndef DSW_DEFINES_SVH
`define DSW_DEFINES_SVH
`define DSW_ADDR_ACTION 16'h1c08
`define DSW_ADDR_STOPF 16'h1c0a
`define DSW_ADDR_LATCHED 16'h1c18
`define DSW_ADDR_ACTIVE 16'h1c16
`define DSW_WARN_GENERAL 0
`define DSW_WARN_AUTO_MASK 16'h2c00
`define DSW_WARN_VALID_MASK 16'h3ff7
`define DSW_ACT_VALID_MASK 16'h7bdf
`define DSW_STANDSTILL_RPM 16'h0009
`define DSW_WORD_RESET 16'h0000
`define DSW_PWR_SYNC_RESET 2'h3
`endif

// ---- pkg/dsw_pkg.sv ----
// Types shared by the drive status word bank.
// Assumes dsw_defines.svh is on the include path.
`default_nettype none
package dsw_pkg;
   typedef struct packed
   {
      logic [4:0] err_class;
      logic pos_dir;
      logic neg_dir;
      logic in_window;
      logic pg_stopped;
      logic pg_decel;
      logic pg_accel;
      logic pg_const;
   } dsw_motion_type;

   typedef struct packed
   {
      logic [15:0] active_ff;
      logic [15:0] latched_ff;
      logic [15:0] action_ff;
      logic [15:0] stopf_ff;
      logic [15:0] rdata_ff;
      logic rvalid_ff;
      logic [1:0] pwr_meta_ff;
      logic [1:0] pwr_sync_ff;
   } dsw_state_type;
endpackage : dsw_pkg
`default_nettype wire

// ---- tb/dsw_bank_tb.sv ----
// Self-checking bench for the drive status word bank.
// Assumes dsw_pkg and dsw_master are compiled first.
`default_nettype none
module dsw_bank_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rst_n, pin_a, pin_b, fclr, strobe, rd_en, rd_valid;
   logic [10:0] w;
   logic [15:0] speed, code, rd_addr, rd_data, active, latched, d;
   dsw_pkg::dsw_motion_type motion;
   int mismatches, comparisons, cyc;
   // One warning condition per row, expected word beside it
   logic [15:0] exp_tab [11] = '{16'h0003, 16'h0005, 16'h0011, 16'h0021, 16'h0041,
      16'h0081, 16'h0101, 16'h0201, 16'h0801, 16'h1001, 16'h2001};
   dsw_bank uut (.clk(clk), .rst_n(rst_n), .power_removal_input_a(pin_a),
      .power_removal_input_b(pin_b), .warn_power_stage_hot(w[0]), .warn_motor_hot(w[1]),
      .warn_i2t_power_stage(w[2]), .warn_i2t_motor(w[3]), .warn_i2t_brake_res(w[4]),
      .warn_can(w[5]), .warn_encoder(w[6]), .warn_rs485(w[7]), .warn_dc_undervolt(w[8]),
      .warn_fieldbus3(w[9]), .warn_pos_invalid(w[10]), .fault_clear_command(fclr),
      .speed_abs_rpm(speed), .motion(motion), .stop_fault_strobe(strobe),
      .stop_fault_code(code), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
      .rd_valid(rd_valid), .active_warning_word(active), .latched_warning_word(latched));
   dsw_master fbm (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
      .rd_valid(rd_valid));
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask : step
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      comparisons++;
      if (got !== exp)
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      if (got !== exp)
         mismatches++;
   endtask : chk
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   initial
   begin
      // Starts low from its declaration, so no false edge at time zero
      forever #12.5 clk = ~clk;
   end
   // Whole run needs some 120 cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         mismatches++;
         end_sim();
      end
   end
   initial
   begin
      rst_n = 1'b0; pin_a = 1'b1; pin_b = 1'b1; fclr = 1'b0; strobe = 1'b0; w = '0;
      speed = 16'h0000; code = 16'h0000; motion = '0;
      step(2);
      rst_n = 1'b1;
      chk(latched, 16'h0000, "reset latched");
      for (int i = 0; i < 11; i++)
      begin
         w = 11'h001 << i;
         step(3);
         chk(active, exp_tab[i], "active row");
         chk(latched, exp_tab[i], "latched row");
         w = '0;
         fclr = 1'b1;
         step(1);
         fclr = 1'b0;
         step(2);
      end
      $display("table done");
      w = 11'h001;
      step(1);
      w = '0;
      step(3);
      chk(active, 16'h0000, "active drop");
      chk(latched, 16'h0003, "hold");
      fclr = 1'b1;
      step(1);
      fclr = 1'b0;
      step(2);
      chk(latched, 16'h0000, "clear");
      $display("latch and clear done");
      w = 11'h001;
      fclr = 1'b1;
      step(1);
      fclr = 1'b0;
      w = '0;
      step(1);
      chk(latched, 16'h0003, "set beats clear");
      fclr = 1'b1;
      step(1);
      fclr = 1'b0;
      step(1);
      chk(latched, 16'h0000, "clear after set");
      $display("set against clear done");
      pin_a = 1'b0;
      w = 11'h502;
      step(5);
      chk(active, 16'h2c05, "auto set");
      pin_a = 1'b1;
      w = '0;
      step(5);
      chk(latched, 16'h0005, "auto clear");
      fbm.read(16'h1c18, d);
      chk(d, 16'h0005, "latched read");
      pin_b = 1'b0;
      step(5);
      fbm.read(16'h1c16, d);
      chk(d, 16'h0401, "pin b");
      pin_b = 1'b1;
      fbm.read(16'h1c00, d);
      chk(d, 16'h0000, "unmapped");
      $display("auto clear done");
      motion = '1;
      speed = 16'h0008;
      step(2);
      fbm.read(16'h1c08, d);
      chk(d, 16'h7bdf, "action all");
      speed = 16'h0009;
      step(2);
      fbm.read(16'h1c08, d);
      chk(d, 16'h7b9f, "standstill edge");
      motion = '{err_class: 5'h04, default: 1'b0};
      speed = 16'hffff;
      step(2);
      fbm.read(16'h1c08, d);
      chk(d, 16'h0004, "class 2");
      code = 16'ha5c3;
      strobe = 1'b1;
      step(1);
      strobe = 1'b0;
      code = 16'h0000;
      step(1);
      fbm.read(16'h1c0a, d);
      chk(d, 16'ha5c3, "stop code");
      $display("action and stop code done");
      w = 11'h001;
      step(3);
      rst_n = 1'b0;
      w = '0;
      step(1);
      rst_n = 1'b1;
      step(2);
      chk(latched, 16'h0000, "mid reset");
      $display("reset done");
      end_sim();
   end
endmodule : dsw_bank_tb
`default_nettype wire

// ---- tb/dsw_master.sv ----
// Fieldbus master model that polls the status words of the drive bank.
// Assumes the bench clock; requests launch at the falling edge.
`default_nettype none
module dsw_master
(
   input wire logic clk,
   output logic rd_en,
   output logic [15:0] rd_addr,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      rd_en = 1'b0;
      rd_addr = 16'h0000;
   end
   // One word per call; bits read in the single mode in use
   task automatic read(input logic [15:0] a, output logic [15:0] d);
      int n;
      @(negedge clk);
      rd_en = 1'b1;
      rd_addr = a;
      @(negedge clk);
      rd_en = 1'b0;
      // Idle address inverted so a stale decode cannot pass
      rd_addr = ~a;
      n = 0;
      while (rd_valid !== 1'b1 && n < 4)
      begin
         @(negedge clk);
         n++;
      end
      d = (rd_valid === 1'b1) ? rd_data : 16'hxxxx;
   endtask : read
endmodule : dsw_master
`default_nettype wire
